// [wwdt_core.sv]
// Windowed watchdog core with register port, sticky events and interrupt.
// Assumes straps are stable and power, OSC_STARTUP_TIMER and clear inputs are synchronous.
`timescale 1ns/1ps
`include "wwdt_consts.svh"
`default_nettype none

module wwdt_core (
    // Clock and reset.
    input  wire logic       clk_sys_i,
    input  wire logic       nrst_i,
    // Configuration straps and power-on indication.
    input  wire logic [1:0] wd_mode_cfg_i,
    input  wire logic [4:0] wd_period_cfg_i,
    input  wire logic [2:0] wd_clk_cfg_i,
    input  wire logic [2:0] open_span_cfg_i,
    input  wire logic       por_i,
    // Core status and commands.
    input  wire logic [1:0] pwr_state_i,
    input  wire logic       osc_startup_timer_i,
    input  wire logic       wd_clear_instr_i,
    // Register port.
    input  wire logic [3:0] reg_addr_i,
    input  wire logic [7:0] reg_wdata_i,
    input  wire logic       reg_wr_i,
    input  wire logic       reg_rd_i,
    output logic      [7:0] reg_rdata_o,
    // Outcomes.
    output logic            wd_reset_o,
    output logic            wd_wake_o,
    output logic            timeout_status_o,
    output logic            powerdown_status_o,
    output logic            irq_o
);

    ////////////////////////////////////////////////////////////////////////
    // Registers and state.
    logic [4:0]  period_r;
    logic        sw_on_r;
    logic [2:0]  clk_sel_r;
    logic [2:0]  span_r;
    logic        viol_flag_r;
    logic        armed_r;
    logic [`WWDT_CNT_W-1:0] cnt_r;
    logic [12:0] div_r;
    logic        tick_r;
    logic [1:0]  pwr_q_r;
    logic [`WWDT_EV_W-1:0] ev_r;
    logic [`WWDT_EV_W-1:0] mask_r;
    logic        strap_done_r;
    logic        por_meta_r;
    logic        por_sync_r;

    wwdt_pkg::wwdt_pwr_t pwr;
    assign pwr = wwdt_pkg::wwdt_pwr_t'(pwr_state_i);

    logic        active;
    logic        windowed;
    logic [2:0]  span_eff;
    logic [2:0]  clk_eff;
    logic [4:0]  ps_eff;
    logic [`WWDT_CNT_W-1:0] limit;
    logic [`WWDT_CNT_W-1:0] delay;
    logic        expire;
    logic        in_window;
    logic        ctl_write;
    logic        arm_read;
    logic        violate;
    logic        good_clear;
    logic        sleep_edge;
    logic        clr_cnt;
    logic        fire;

    // Mode table of the four configuration settings.
    always_comb begin
        case (wd_mode_cfg_i)
            2'b11:   active = 1'b1;
            2'b10:   active = (pwr != wwdt_pkg::WWDT_SLEEP);
            2'b01:   active = sw_on_r;
            default: active = 1'b0;
        endcase
    end

    // Window and clock sources; the register only counts when strapped 111.
    assign span_eff = (open_span_cfg_i == `WWDT_WIN_STRAP_SW) ?
                      span_r : open_span_cfg_i;
    assign clk_eff  = (wd_clk_cfg_i == `WWDT_CS_STRAP_SW) ?
                      clk_sel_r : wd_clk_cfg_i;
    assign windowed = (span_eff != `WWDT_WIN_FULL);

    // Reserved selects fall back to the shortest period.
    assign ps_eff = (period_r > `WWDT_PS_MAX) ? 5'h00 : period_r;
    assign limit  = `WWDT_CNT_W'(1) << (`WWDT_BASE_LOG2 + ps_eff);

    // Closed part is (7 - span)/8 of the period, 87.5% down to 0.
    assign delay = `WWDT_CNT_W'((limit >> 3) *
                   (`WWDT_CNT_W'(3'h7 - span_eff)));
    assign in_window = (cnt_r >= delay);

    assign ctl_write = reg_wr_i && (reg_addr_i == `WWDT_ADDR_CTL0 ||
                                    reg_addr_i == `WWDT_ADDR_CTL1);
    assign arm_read  = reg_rd_i && (reg_addr_i == `WWDT_ADDR_CTL0);

    // With a window set, a clear is bad outside the window or when not armed.
    assign violate = active && windowed && wd_clear_instr_i &&
                     (!in_window || !armed_r);
    assign good_clear = active && wd_clear_instr_i && !violate;
    assign expire = active && tick_r && (cnt_r >= limit - 1'b1);

    assign sleep_edge = (pwr_q_r == 2'(wwdt_pkg::WWDT_SLEEP)) !=
                        (pwr == wwdt_pkg::WWDT_SLEEP);
    // A violation requests a device reset while running, and any reset clears the count.
    assign clr_cnt = good_clear || violate || sleep_edge || !active ||
                     osc_startup_timer_i || ctl_write || expire;
    assign fire = expire || violate;

    ////////////////////////////////////////////////////////////////////////
    // Oscillator tick: one-cycle enable at the selected rate.
    // Dividing by whole system clocks leaves the low rate a hair fast,
    // which is far inside the tolerance of the oscillator it stands for.
    always_ff @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            div_r  <= 13'h0000;
            tick_r <= 1'b0;
        end else if (div_r == 13'((clk_eff == 3'h1 ? `WWDT_MF_DIV :
                                   `WWDT_LF_DIV) - 1)) begin
            div_r  <= 13'h0000;
            tick_r <= 1'b1;
        end else begin
            div_r  <= div_r + 13'h0001;
            tick_r <= 1'b0;
        end
    end

    // Previous power state for Sleep entry and exit.
    always_ff @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            pwr_q_r <= 2'h0;
        end else begin
            pwr_q_r <= pwr_state_i;
        end
    end

    // Watchdog count.
    always_ff @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            cnt_r <= '0;
        end else if (clr_cnt) begin
            cnt_r <= '0;
        end else if (tick_r) begin
            cnt_r <= cnt_r + 1'b1;
        end
    end

    // Arming: a read of control zero arms, any clear attempt disarms.
    // A read that meets a clear in one cycle wins, so that clear is judged
    // on the arming from before it and the following one is armed.
    always_ff @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            armed_r <= 1'b0;
        end else if (arm_read) begin
            armed_r <= 1'b1;
        end else if (wd_clear_instr_i || clr_cnt) begin
            armed_r <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Control registers; strap-loaded fields are caught after reset release.
    always_ff @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            strap_done_r <= 1'b0;
            period_r     <= `WWDT_PS_DEFAULT;
            sw_on_r      <= 1'b0;
            clk_sel_r    <= 3'h0;
            span_r       <= 3'h0;
        end else if (!strap_done_r) begin
            strap_done_r <= 1'b1;
            period_r     <= (wd_period_cfg_i == `WWDT_PS_STRAP_SW) ?
                            `WWDT_PS_DEFAULT : wd_period_cfg_i;
            span_r       <= open_span_cfg_i;
        end else if (reg_wr_i && reg_addr_i == `WWDT_ADDR_CTL0) begin
            if (wd_period_cfg_i == `WWDT_PS_STRAP_SW) begin
                period_r <= reg_wdata_i[5:1];
            end
            sw_on_r <= reg_wdata_i[0];
        end else if (reg_wr_i && reg_addr_i == `WWDT_ADDR_CTL1) begin
            if (wd_clk_cfg_i == `WWDT_CS_STRAP_SW) begin
                clk_sel_r <= reg_wdata_i[6:4];
            end
            if (open_span_cfg_i == `WWDT_WIN_STRAP_SW) begin
                span_r <= reg_wdata_i[2:0];
            end
        end
    end

    // Power-on indication comes from the supply detector, not from this
    // clock, so it passes two flip-flops before the flag logic reads it.
    // Both stages come up set: a reset means a power-on may just have passed.
    always_ff @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            por_meta_r <= 1'b1;
            por_sync_r <= 1'b1;
        end else begin
            por_meta_r <= por_i;
            por_sync_r <= por_meta_r;
        end
    end

    // Violation flag: power-on sets, violation clears, firmware may set.
    always_ff @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            viol_flag_r <= 1'b1;
        end else if (por_sync_r) begin
            viol_flag_r <= 1'b1;
        end else if (violate) begin
            viol_flag_r <= 1'b0;
        end else if (reg_wr_i && reg_addr_i == `WWDT_ADDR_PWR &&
                     reg_wdata_i[0]) begin
            viol_flag_r <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outcomes: reset when awake, wake when idle or asleep.
    always_ff @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            wd_reset_o         <= 1'b0;
            wd_wake_o          <= 1'b0;
            timeout_status_o   <= 1'b1;
            powerdown_status_o <= 1'b1;
        end else begin
            wd_reset_o <= fire && (pwr == wwdt_pkg::WWDT_RUN);
            wd_wake_o  <= fire && (pwr != wwdt_pkg::WWDT_RUN);
            if (pwr == wwdt_pkg::WWDT_SLEEP && expire) begin
                timeout_status_o   <= 1'b0;
                powerdown_status_o <= 1'b0;
            end else if (good_clear) begin
                timeout_status_o   <= 1'b1;
                powerdown_status_o <= 1'b1;
            end
        end
    end

    // Sticky events; set wins over a write-one-to-clear.
    genvar g;
    generate
        for (g = 0; g < `WWDT_EV_W; g++) begin : g_ev
            logic set_ev;
            assign set_ev = (g == `WWDT_EV_TIMEOUT) ? expire :
                            (g == `WWDT_EV_VIOLATE) ? violate :
                            (fire && pwr != wwdt_pkg::WWDT_RUN);
            always_ff @(posedge clk_sys_i or negedge nrst_i) begin
                if (!nrst_i) begin
                    ev_r[g] <= 1'b0;
                end else if (set_ev) begin
                    ev_r[g] <= 1'b1;
                end else if (reg_wr_i && reg_addr_i == `WWDT_ADDR_IRQ_STAT &&
                             reg_wdata_i[g]) begin
                    ev_r[g] <= 1'b0;
                end
            end
        end
    endgenerate

    // Mask register and interrupt level.
    always_ff @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            mask_r <= '0;
            irq_o  <= 1'b0;
        end else begin
            if (reg_wr_i && reg_addr_i == `WWDT_ADDR_IRQ_MASK) begin
                mask_r <= reg_wdata_i[`WWDT_EV_W-1:0];
            end
            irq_o <= |(ev_r & mask_r);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Read data one cycle after the strobe; unmapped reads return zero.
    always_ff @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            reg_rdata_o <= 8'h00;
        end else if (reg_rd_i) begin
            if (reg_addr_i == `WWDT_ADDR_CTL0) begin
                reg_rdata_o <= {2'b00, period_r, sw_on_r};
            end else if (reg_addr_i == `WWDT_ADDR_CTL1) begin
                reg_rdata_o <= {1'b0, clk_eff, 1'b0, span_eff};
            end else if (reg_addr_i == `WWDT_ADDR_CNT_LO) begin
                reg_rdata_o <= cnt_r[7:0];
            end else if (reg_addr_i == `WWDT_ADDR_CNT_MID) begin
                reg_rdata_o <= cnt_r[15:8];
            end else if (reg_addr_i == `WWDT_ADDR_TMR) begin
                reg_rdata_o <= {1'b0, cnt_r[21:18], armed_r, cnt_r[17:16]};
            end else if (reg_addr_i == `WWDT_ADDR_PWR) begin
                reg_rdata_o <= {7'h00, viol_flag_r};
            end else if (reg_addr_i == `WWDT_ADDR_IRQ_STAT) begin
                reg_rdata_o <= {5'h00, ev_r};
            end else if (reg_addr_i == `WWDT_ADDR_IRQ_MASK) begin
                reg_rdata_o <= {5'h00, mask_r};
            end else begin
                reg_rdata_o <= 8'h00;
            end
        end else begin
            reg_rdata_o <= 8'h00;
        end
    end

endmodule

`default_nettype wire

// [wwdt_consts.svh]
// Constants of the windowed watchdog: register offsets, field layout,
// reset values and divider counts.
// Assumes a 200 MHz system clock and a plain register port.
`ifndef WWDT_CONSTS_SVH
`define WWDT_CONSTS_SVH

// Register offsets (byte addresses on the 8-bit register port).
`define WWDT_ADDR_CTL0      4'h0
`define WWDT_ADDR_CTL1      4'h1
`define WWDT_ADDR_CNT_LO    4'h2
`define WWDT_ADDR_CNT_MID   4'h3
`define WWDT_ADDR_TMR       4'h4
`define WWDT_ADDR_PWR       4'h5
`define WWDT_ADDR_IRQ_STAT  4'h6
`define WWDT_ADDR_IRQ_MASK  4'h7

// Reset value, software strap codes and field limits.
`define WWDT_PS_DEFAULT     5'h0b
`define WWDT_PS_STRAP_SW    5'h1f
`define WWDT_PS_MAX         5'h12
`define WWDT_CS_STRAP_SW    3'h7
`define WWDT_WIN_STRAP_SW   3'h7
`define WWDT_WIN_FULL       3'h7

// Oscillator tick dividers from 200 MHz: 31 kHz and 31.25 kHz.
`define WWDT_CLK_HZ         200000000
`define WWDT_LF_HZ          31000
`define WWDT_MF_HZ          31250
`define WWDT_LF_DIV         (`WWDT_CLK_HZ / `WWDT_LF_HZ)
`define WWDT_MF_DIV         (`WWDT_CLK_HZ / `WWDT_MF_HZ)

// Prescaler is 5 bits of base 1:32 plus up to 18 doublings.
`define WWDT_BASE_LOG2      5
`define WWDT_CNT_W          28

// Event bits in the interrupt status register.
`define WWDT_EV_TIMEOUT     0
`define WWDT_EV_VIOLATE     1
`define WWDT_EV_WAKE        2
`define WWDT_EV_W           3

`endif

// [wwdt_pkg.sv]
// Types shared by the windowed watchdog.
// Assumes the constants header is included where numbers are needed.
`default_nettype none

package wwdt_pkg;
    // Power state of the core as seen by the watchdog.
    typedef enum logic [1:0] {
        WWDT_RUN   = 2'b00,
        WWDT_IDLE  = 2'b01,
        WWDT_SLEEP = 2'b10
    } wwdt_pwr_t;
endpackage

`default_nettype wire

// [wwdt_monitor.sv]
// Port checker for the windowed watchdog core.
// Assumes it is bound to wwdt_core and sees only that module's ports.
`timescale 1ns/1ps
`default_nettype none

module wwdt_monitor (
    // Clock and reset.
    input wire logic       clk_sys_i,
    input wire logic       nrst_i,
    // Straps and core state.
    input wire logic [1:0] wd_mode_cfg_i,
    input wire logic [2:0] open_span_cfg_i,
    input wire logic [1:0] pwr_state_i,
    input wire logic       osc_startup_timer_i,
    input wire logic       wd_clear_instr_i,
    // Register port.
    input wire logic [3:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic       reg_wr_i,
    input wire logic       reg_rd_i,
    input wire logic [7:0] reg_rdata_o,
    // Outcomes.
    input wire logic       wd_reset_o,
    input wire logic       wd_wake_o,
    input wire logic       timeout_status_o,
    input wire logic       irq_o
);
    logic       armed_r;
    logic       sw_on_r;
    logic [9:0] since_r;
    logic       live;
    logic       run;

    // Field-owned windows are left out, so only strap windows are judged.
    assign run  = pwr_state_i == wwdt_pkg::WWDT_RUN;
    assign live = open_span_cfg_i != 3'h7 && !osc_startup_timer_i && run
        && (wd_mode_cfg_i[1] || (wd_mode_cfg_i[0] && sw_on_r));

    // Arming shadow: a control-zero read arms, a clear alone disarms.
    always_ff @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            armed_r <= 1'b0;
        end else if (wd_clear_instr_i || (reg_rd_i && reg_addr_i == 4'h0)) begin
            armed_r <= reg_rd_i && reg_addr_i == 4'h0;
        end
    end

    // Software enable shadow, kept from writes to control zero.
    always_ff @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            sw_on_r <= 1'b0;
        end else if (reg_wr_i && reg_addr_i == 4'h0) begin
            sw_on_r <= reg_wdata_i[0];
        end
    end

    // Cycles since the count was cleared; any window delay is far longer.
    // Idle keeps the count running, Sleep holds it clear.
    always_ff @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            since_r <= 10'h000;
        end else if (wd_clear_instr_i || osc_startup_timer_i
                     || pwr_state_i == wwdt_pkg::WWDT_SLEEP
                     || (reg_wr_i && reg_addr_i[3:1] == 3'h0)) begin
            since_r <= 10'h000;
        end else if (since_r != 10'h3ff) begin
            since_r <= since_r + 10'h001;
        end
    end

    default clocking cb @(posedge clk_sys_i);
    endclocking
    default disable iff (!nrst_i);

    chk_reset_one_cycle: assert property (wd_reset_o |=> !wd_reset_o)
        else $error("reset request longer than one cycle");
    chk_rdata_only_read: assert property (!reg_rd_i |=> reg_rdata_o == 8'h00)
        else $error("read data outside a read answer");
    chk_unarmed_clear: assert property (
        wd_clear_instr_i && !armed_r && live |-> ##[1:3] wd_reset_o)
        else $error("unarmed clear gave no reset");
    chk_early_clear: assert property (
        wd_clear_instr_i && armed_r && live && since_r < 10'h3e8
        |-> ##[1:3] wd_reset_o)
        else $error("early clear gave no reset");
    chk_mode_off_quiet: assert property (
        wd_mode_cfg_i == 2'b00 |-> !wd_reset_o && !wd_wake_o)
        else $error("disabled watchdog acted");
    chk_sw_off_quiet: assert property (
        wd_mode_cfg_i == 2'b01 && !sw_on_r && !$past(sw_on_r) |-> !wd_reset_o)
        else $error("software-off watchdog reset");
    chk_lowpwr_no_reset: assert property (
        !run && !$past(run) |-> !wd_reset_o)
        else $error("reset while idle or asleep");
    chk_wake_low_power: assert property (
        wd_wake_o |-> $past(pwr_state_i) != wwdt_pkg::WWDT_RUN)
        else $error("wake while running");
    chk_timeout_in_sleep: assert property (
        $fell(timeout_status_o) |-> $past(pwr_state_i) == wwdt_pkg::WWDT_SLEEP)
        else $error("time-out flag fell outside sleep");

    cov_unarmed: cover property (wd_clear_instr_i && !armed_r && live);
    cov_reset: cover property (wd_reset_o);
    cov_irq: cover property ($rose(irq_o));
endmodule

bind wwdt_core wwdt_monitor u_mon (.clk_sys_i, .nrst_i, .wd_mode_cfg_i,
    .open_span_cfg_i, .pwr_state_i, .osc_startup_timer_i, .wd_clear_instr_i,
    .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o,
    .wd_reset_o, .wd_wake_o, .timeout_status_o, .irq_o);

`default_nettype wire

// [wwdt_cpu_model.sv]
// Stand-in for the CPU core: issues clear instructions, changes power state.
// Assumes bench commands are one-cycle pulses on the system clock.
`timescale 1ns/1ps
`default_nettype none

module wwdt_cpu_model (
    // Clock and reset.
    input  wire logic       clk_sys_i,
    input  wire logic       nrst_i,
    // Bench commands.
    input  wire logic       do_clear_i,
    input  wire logic [1:0] go_pwr_i,
    input  wire logic       go_pwr_vld_i,
    // Watchdog side.
    input  wire logic       wd_wake_i,
    output logic            wd_clear_instr_o,
    output logic [1:0]      pwr_state_o
);
    // A halted core executes nothing, so clears leave it only while running.
    always_ff @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            wd_clear_instr_o <= 1'b0;
        end else begin
            wd_clear_instr_o <= do_clear_i && pwr_state_o == 2'b00;
        end
    end

    // A watchdog wake resumes execution at once.
    always_ff @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            pwr_state_o <= 2'b00;
        end else if (wd_wake_i) begin
            pwr_state_o <= 2'b00;
        end else if (go_pwr_vld_i) begin
            pwr_state_o <= go_pwr_i;
        end
    end
endmodule

`default_nettype wire

// [windowed_watchdog_timer_tb.sv]
// Self-checking bench for the windowed watchdog core.
// Assumes the core, its checker and the CPU stand-in are compiled first.
`timescale 1ns/1ps
`default_nettype none

module windowed_watchdog_timer_tb;
    logic       clk_sys_i = 1'b0;
    logic       nrst_i = 1'b0;
    logic [1:0] wd_mode_cfg_i = 2'b11;
    logic [2:0] open_span_cfg_i = 3'h0;
    logic       por_i = 1'b1;
    logic       osc_startup_timer_i = 1'b0;
    logic [3:0] reg_addr_i = 4'h0;
    logic [7:0] reg_wdata_i = 8'h00;
    logic       reg_wr_i = 1'b0;
    logic       reg_rd_i = 1'b0;
    logic       do_clr = 1'b0;
    logic [1:0] go_pwr = 2'b00;
    logic       go_vld = 1'b0;
    logic [7:0] reg_rdata_o;
    logic [1:0] pwr_state_i;
    logic       wd_clear_instr_i;
    logic       wd_reset_o;
    logic       wd_wake_o;
    logic       timeout_status_o;
    logic       powerdown_status_o;
    logic       irq_o;
    logic       rs;
    logic       wk;
    logic [7:0] d;
    int         num_errors = 0;
    int         checks_done = 0;
    // Rows: {write, address, data, expected read}.
    logic [20:0] regs [0:13] = '{21'h00016, 21'h10000, 21'h50001,
        21'h60000, 21'h90000, 21'h100100, 21'h00001, 21'h102400,
        21'h111000, 21'h10010, 21'h00024, 21'h40004, 21'h170700, 21'h70007};
    // Rows: {mode, enable, window strap, control one, reset expected}.
    logic [14:0] modes [0:7] = '{15'h6001, 15'h4001, 15'h2000, 15'h3001,
        15'h1000, 15'h6e0e, 15'h6e01, 15'h600f};

    always #2.5 clk_sys_i = ~clk_sys_i;

    // Period and clock straps hand both fields to software.
    wwdt_core dut (.clk_sys_i, .nrst_i, .wd_mode_cfg_i,
        .wd_period_cfg_i(5'h1f), .wd_clk_cfg_i(3'h7), .open_span_cfg_i,
        .por_i, .pwr_state_i, .osc_startup_timer_i, .wd_clear_instr_i,
        .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o,
        .wd_reset_o, .wd_wake_o, .timeout_status_o, .powerdown_status_o,
        .irq_o);
    wwdt_cpu_model u_cpu (.clk_sys_i, .nrst_i, .do_clear_i(do_clr),
        .go_pwr_i(go_pwr), .go_pwr_vld_i(go_vld), .wd_wake_i(wd_wake_o),
        .wd_clear_instr_o(wd_clear_instr_i), .pwr_state_o(pwr_state_i));

    task automatic stop_test();
        $display("checks %0d errors %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
        checks_done++;
        if (got !== exp) begin
            num_errors++;
            $display("ERROR %0t got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic chk_bit(input logic got, input logic exp);
        chk_byte({7'h00, got}, {7'h00, exp});
    endtask

    // Straps change only under reset, as the core loads the window strap field once after release.
    task automatic do_reset(input logic [1:0] m, input logic [2:0] w);
        nrst_i <= 1'b0;
        wd_mode_cfg_i <= m;
        open_span_cfg_i <= w;
        repeat (10) @(posedge clk_sys_i);
        nrst_i <= 1'b1;
        repeat (2) @(posedge clk_sys_i);
    endtask

    task automatic wr_reg(input logic [3:0] a, input logic [7:0] v);
        @(posedge clk_sys_i);
        reg_addr_i <= a;
        reg_wdata_i <= v;
        reg_wr_i <= 1'b1;
        @(posedge clk_sys_i);
        reg_wr_i <= 1'b0;
    endtask

    // Read data stands only in the cycle after the strobe.
    task automatic rd_reg(input logic [3:0] a, output logic [7:0] v);
        @(posedge clk_sys_i);
        reg_addr_i <= a;
        reg_rd_i <= 1'b1;
        @(posedge clk_sys_i);
        reg_rd_i <= 1'b0;
        @(posedge clk_sys_i);
        v = reg_rdata_o;
    endtask

    // Issue one clear and collect any reset or wake pulse that follows.
    task automatic clear_watch();
        rs = 1'b0;
        wk = 1'b0;
        @(posedge clk_sys_i);
        do_clr <= 1'b1;
        @(posedge clk_sys_i);
        do_clr <= 1'b0;
        repeat (6) begin
            @(posedge clk_sys_i);
            rs = rs | wd_reset_o;
            wk = wk | wd_wake_o;
        end
    endtask

    initial begin
        repeat (90000) @(posedge clk_sys_i);
        num_errors++;
        $display("ERROR %0t run did not finish", $time);
        stop_test();
    end

    initial begin
        do_reset(2'b11, 3'h0);
        por_i <= 1'b0;
        chk_byte({timeout_status_o, powerdown_status_o, irq_o, wd_reset_o,
            wd_wake_o, 3'h0}, 8'hc0);
        for (int i = 0; i < 14; i++) begin
            if (regs[i][20]) begin
                wr_reg(regs[i][19:16], regs[i][15:8]);
            end else begin
                rd_reg(regs[i][19:16], d);
                chk_byte(d, regs[i][7:0]);
            end
        end
        $display("register table done");
        clear_watch();
        chk_bit(rs, 1'b1);
        clear_watch();
        chk_bit(rs, 1'b1);
        rd_reg(4'h6, d);
        chk_byte(d, 8'h02);
        chk_bit(irq_o, 1'b1);
        rd_reg(4'h5, d);
        chk_byte(d, 8'h00);
        wr_reg(4'h5, 8'h01);
        rd_reg(4'h5, d);
        chk_byte(d, 8'h01);
        wr_reg(4'h7, 8'h00);
        wr_reg(4'h6, 8'h02);
        repeat (2) @(posedge clk_sys_i);
        chk_bit(irq_o, 1'b0);
        clear_watch();
        rd_reg(4'h6, d);
        chk_byte({d[1], irq_o, 6'h00}, 8'h80);
        wr_reg(4'h7, 8'h02);
        repeat (2) @(posedge clk_sys_i);
        chk_bit(irq_o, 1'b1);
        $display("violation and interrupt done");
        osc_startup_timer_i <= 1'b1;
        repeat (13000) @(posedge clk_sys_i);
        rd_reg(4'h2, d);
        chk_byte(d, 8'h00);
        osc_startup_timer_i <= 1'b0;
        repeat (13000) @(posedge clk_sys_i);
        rd_reg(4'h2, d);
        chk_bit(d >= 8'h02 && d <= 8'h03, 1'b1);
        go_pwr <= 2'b10;
        go_vld <= 1'b1;
        @(posedge clk_sys_i);
        go_pwr <= 2'b00;
        repeat (3) @(posedge clk_sys_i);
        go_vld <= 1'b0;
        rd_reg(4'h2, d);
        chk_byte(d, 8'h00);
        $display("count clearing done");
        for (int i = 0; i < 8; i++) begin
            do_reset(modes[i][14:13], modes[i][11:9]);
            wr_reg(4'h0, {7'h0b, modes[i][12]});
            wr_reg(4'h1, modes[i][8:1]);
            clear_watch();
            chk_bit(rs, modes[i][0]);
            chk_bit(wk, 1'b0);
        end
        $display("mode table done");
        // Register window of 87.5 percent on the mid clock; the reserved
        // period select must act as the shortest period, or the window
        // would still be shut when the clears below arrive.
        do_reset(2'b11, 3'h7);
        wr_reg(4'h0, 8'h26);
        rd_reg(4'h0, d);
        chk_byte(d, 8'h26);
        wr_reg(4'h1, 8'h16);
        repeat (26000) @(posedge clk_sys_i);
        clear_watch();
        chk_bit(rs, 1'b1);
        repeat (13000) @(posedge clk_sys_i);
        go_pwr <= 2'b01;
        go_vld <= 1'b1;
        @(posedge clk_sys_i);
        go_pwr <= 2'b00;
        repeat (3) @(posedge clk_sys_i);
        go_vld <= 1'b0;
        repeat (13000) @(posedge clk_sys_i);
        rd_reg(4'h0, d);
        clear_watch();
        chk_bit(rs, 1'b0);
        rd_reg(4'h0, d);
        clear_watch();
        chk_bit(rs, 1'b1);
        $display("open window done");
        stop_test();
    end
endmodule

`default_nettype wire
